// ### design/pin_sync.sv
// Two-flop synchroniser with edge detection for one asynchronous pin
module pin_sync (
    input  wire logic ref_clk, // Reference clock
    input  wire logic nrst,    // Async reset, active low
    input  wire logic pin,     // Asynchronous input
    output logic      level,   // Synchronised level
    output logic      rise,    // One-cycle pulse on rising edge
    output logic      fall     // One-cycle pulse on falling edge
);
    logic stage1_q;
    logic stage2_q;
    logic last_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            last_q   <= 1'b0;
        end else begin
            stage1_q <= pin;
            stage2_q <= stage1_q;
            last_q   <= stage2_q;
        end
    end

    assign level = stage2_q;
    assign rise  = stage2_q & ~last_q;
    assign fall  = ~stage2_q & last_q;
endmodule : pin_sync

// ### design/rf_downlink_ppm_decoder.sv
// Downlink pulse-position decoder: pauses timed on the carrier become bytes
// How it works
// - Pauses of either modulation depth are accepted; carrier gaps are bridged.
// - 1-of-256: one pause among 256 slots of 256 carrier cycles gives a byte.
// - 1-of-256 byte lasts 65536 carrier cycles, carrier over 8192 per bit.
// - Slot index is the value: first slot 00h, last slot FFh.
// - 1-of-4: one pause among 4 slots of 256 carrier cycles gives two bits.
// - Four pairs build a byte, first pair into the least significant bits.
// - 1-of-4 byte lasts 4096 carrier cycles, carrier over 512 per bit.
// - Frames are bounded by delimiters made from coding violations.
// - Receiver is ready again 311.5 us after a response ends, not sooner.
// - Receiver is ready 0.1 ms after the field switches on.
// - Reader talks first; no reception while the tag transmits.
// - Start delimiter shape selects 1-of-256 or 1-of-4.
// - One end delimiter shape serves both modes.
module rf_downlink_ppm_decoder
    import rf_ppm_pkg::*;
#(
    parameter int unsigned TURN_CYC = TURN_CYC_DEF, // Turnaround hold-off in reference cycles
    parameter logic [7:0]  FLY_GAP  = FLY_GAP_DEF,  // Missing-carrier fill-in distance
    parameter logic [15:0] SOF_TOL  = SOF_TOL_DEF   // Delimiter pause tolerance, carrier cycles
) (
    input  wire logic ref_clk,    // 20 MHz reference clock
    input  wire logic nrst,       // Async reset, active low
    input  wire logic carrierClk, // Carrier from the antenna, asynchronous
    input  wire logic pauseN,     // Demodulated pause, low during a pause, asynchronous
    input  wire logic fieldOn,    // Field present, asynchronous
    input  wire logic txBusy,     // Uplink response in progress, same clock
    output rx_out_s   rxOut       // Decoded byte and frame flags
);
    logic      carLevel;
    logic      carRise;
    logic      pauseLevel;
    logic      pauseFall;
    logic      fieldLvl;
    logic      tick;

    pin_sync u_car_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin     (carrierClk),
        .level   (carLevel),
        .rise    (carRise),
        .fall    ()
    );

    pin_sync u_pause_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin     (pauseN),
        .level   (pauseLevel),
        .rise    (),
        .fall    (pauseFall)
    );

    pin_sync u_field_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin     (fieldOn),
        .level   (fieldLvl),
        .rise    (),
        .fall    ()
    );

    // Carrier tick with fill-in
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    logic [7:0] per_q;
    logic [7:0] per_d;
    logic       fly_q;
    logic       fly_d;
    logic       flyTick;

    // bridge carrier gaps
    // A full-depth pause stops the carrier; fill-in keeps the slot count running.
    // First fill-in waits FLY_GAP, later ones follow the learnt period, so no tick is lost
    always_comb begin
        flyTick = fly_q ? (gap_q >= per_q) : (gap_q == FLY_GAP);
        tick    = carRise | flyTick;
        gap_d   = tick ? 8'h00 : gap_q + 8'h01;
        per_d   = per_q;
        fly_d   = fly_q;
        if (carRise) begin
            fly_d = 1'b0;
            // Period only trusted between two real edges
            if (!fly_q) begin
                per_d = gap_q;
            end
        end else if (flyTick) begin
            fly_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 8'h00;
            per_q <= FLY_GAP;
            fly_q <= 1'b1;
        end else begin
            gap_q <= gap_d;
            per_q <= per_d;
            fly_q <= fly_d;
        end
    end

    // Decoder state
    rx_state_e         state_q;
    rx_state_e         state_d;
    logic [15:0]       pos_q;
    logic [15:0]       pos_d;
    logic              got_q;
    logic              got_d;
    logic [7:0]        val_q;
    logic [7:0]        val_d;
    logic [1:0]        pair_q;
    logic [1:0]        pair_d;
    logic [7:0]        sh_q;
    logic [7:0]        sh_d;
    logic              mode4_q;
    logic              mode4_d;
    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] hold_d;
    logic              pwr_q;
    logic              pwr_d;
    rx_out_s           out_q;
    rx_out_s           out_d;
    logic [HOLD_W-1:0] holdTarget;
    logic [15:0]       symLast;
    logic              near4;
    logic              near256;

    always_comb begin
        state_d    = state_q;
        pos_d      = pos_q;
        got_d      = got_q;
        val_d      = val_q;
        pair_d     = pair_q;
        sh_d       = sh_q;
        mode4_d    = mode4_q;
        hold_d     = hold_q;
        pwr_d      = pwr_q;
        out_d      = out_q;
        out_d.valid = 1'b0;
        out_d.sof   = 1'b0;
        out_d.eof   = 1'b0;
        out_d.err   = 1'b0;
        holdTarget = pwr_q ? HOLD_W'(POWERUP_CYC) : HOLD_W'(TURN_CYC);
        symLast    = mode4_q ? SYM4_LAST : SYM256_LAST;
        near4      = (pos_q >= SOF4_GAP - SOF_TOL) && (pos_q <= SOF4_GAP + SOF_TOL);
        near256    = (pos_q >= SOF256_GAP - SOF_TOL) && (pos_q <= SOF256_GAP + SOF_TOL);
        if (tick) begin
            pos_d = pos_q + 16'h0001;
        end
        case (state_q)
            ST_HOLD: begin
                hold_d = hold_q + HOLD_W'(1);
                if (hold_q >= holdTarget) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (pauseFall) begin
                    state_d = ST_SOF;
                    pos_d   = 16'h0000;
                    got_d   = 1'b0;
                end
            end
            ST_SOF: begin
                if (pauseFall) begin
                    if (!got_q && near4) begin
                        mode4_d = 1'b1;
                        got_d   = 1'b1;
                    end else if (!got_q && near256) begin
                        mode4_d = 1'b0;
                        got_d   = 1'b1;
                    end else begin
                        out_d.err = 1'b1;
                        state_d   = ST_IDLE;
                    end
                end else if (tick && pos_q == SOF_LAST) begin
                    if (got_q) begin
                        state_d   = ST_DATA;
                        pos_d     = 16'h0000;
                        got_d     = 1'b0;
                        pair_d    = 2'd0;
                        out_d.sof = 1'b1;
                    end else begin
                        out_d.err = 1'b1;
                        state_d   = ST_IDLE;
                    end
                end
            end
            ST_DATA: begin
                if (pauseFall) begin
                    if (!got_q && pos_q[7]) begin
                        got_d = 1'b1;
                        val_d = pos_q[15:8];
                    end else if (!got_q && pos_q < HALF_CYC) begin
                        out_d.eof = 1'b1;
                        state_d   = ST_IDLE;
                    end else begin
                        out_d.err = 1'b1;
                        state_d   = ST_IDLE;
                    end
                end else if (tick && pos_q == symLast) begin
                    pos_d = 16'h0000;
                    got_d = 1'b0;
                    if (!got_q) begin
                        out_d.err = 1'b1;
                        state_d   = ST_IDLE;
                    end else if (!mode4_q) begin
                        out_d.data  = val_q;
                        out_d.valid = 1'b1;
                    end else begin
                        sh_d   = {val_q[1:0], sh_q[7:2]};
                        pair_d = pair_q + 2'd1;
                        if (pair_q == 2'd3) begin
                            out_d.data  = {val_q[1:0], sh_q[7:2]};
                            out_d.valid = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        // receiver blind while answering; field loss restarts power-up
        if (!fieldLvl || txBusy) begin
            state_d     = ST_HOLD;
            hold_d      = '0;
            pwr_d       = !fieldLvl;
            out_d.valid = 1'b0;
            out_d.sof   = 1'b0;
            out_d.eof   = 1'b0;
            out_d.err   = 1'b0;
        end
        out_d.mode4 = mode4_d;
        out_d.ready = (state_d != ST_HOLD);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_HOLD;
            pos_q   <= 16'h0000;
            got_q   <= 1'b0;
            val_q   <= 8'h00;
            pair_q  <= 2'd0;
            sh_q    <= 8'h00;
            mode4_q <= 1'b0;
            hold_q  <= '0;
            pwr_q   <= 1'b1;
            out_q   <= '0;
        end else begin
            state_q <= state_d;
            pos_q   <= pos_d;
            got_q   <= got_d;
            val_q   <= val_d;
            pair_q  <= pair_d;
            sh_q    <= sh_d;
            mode4_q <= mode4_d;
            hold_q  <= hold_d;
            pwr_q   <= pwr_d;
            out_q   <= out_d;
        end
    end

    assign rxOut = out_q;

    // Checking helpers: cycles since field on, cycles of turnaround wait
    logic [HOLD_W:0] fieldAge_q;
    logic [HOLD_W:0] turnAge_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fieldAge_q <= '0;
            turnAge_q  <= '0;
        end else begin
            fieldAge_q <= !fieldLvl ? '0 : (&fieldAge_q ? fieldAge_q : fieldAge_q + (HOLD_W+1)'(1));
            turnAge_q  <= (state_q == ST_HOLD && !pwr_q && !txBusy && fieldLvl)
                          ? turnAge_q + (HOLD_W+1)'(1) : '0;
        end
    end

    a_byte_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
        out_q.valid |=> !out_q.valid) else $error("byte strobe longer than one cycle");
    a_powerup_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        out_q.ready |-> fieldAge_q >= (HOLD_W+1)'(POWERUP_CYC)) else $error("ready before power-up delay");
    a_turn_bound: assert property (@(posedge ref_clk) disable iff (!nrst)
        turnAge_q <= (HOLD_W+1)'(TURN_CYC + 2)) else $error("turnaround hold-off too long");
    a_tx_blind: assert property (@(posedge ref_clk) disable iff (!nrst)
        txBusy |=> !out_q.ready && !out_q.valid) else $error("receiving while transmitting");
    a_second_half: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state_q == ST_DATA && $rose(got_q)) |-> $past(pos_q[7])) else $error("pause taken in first half");
    a_pair_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (out_q.valid && out_q.mode4) |-> $past(pair_q) == 2'd3 && pair_q == 2'd0)
        else $error("1-of-4 byte not from four pairs");
    a_sof_enters: assert property (@(posedge ref_clk) disable iff (!nrst)
        out_q.sof |-> state_q == ST_DATA && pos_q <= 16'h0001 && $past(got_q))
        else $error("frame start without delimiter");
    a_frame_close: assert property (@(posedge ref_clk) disable iff (!nrst)
        (out_q.eof || out_q.err) |-> state_q != ST_DATA) else $error("frame not closed");
endmodule : rf_downlink_ppm_decoder

// ### include/rf_ppm_pkg.sv
// Constants and types shared by the downlink pulse-position decoder
package rf_ppm_pkg;
    // Reference clock
    localparam int unsigned CLK_NS        = 50;
    // Carrier-cycle timing of the pulse-position symbols
    localparam int unsigned SLOT_NS_X100  = 1888;       // 18.88 us slot
    localparam int unsigned SLOT_CYC      = 256;        // carrier cycles per slot
    localparam int unsigned BYTE256_US_X1000 = 4833000; // 4.833 ms per byte, 1 of 256
    localparam int unsigned BYTE4_NS_X100 = 30208;      // 302.08 us per byte, 1 of 4
    localparam int unsigned RATE256_DIV   = 8192;       // carrier divider per bit, 1 of 256
    localparam int unsigned RATE4_DIV     = 512;        // carrier divider per bit, 1 of 4
    localparam logic [15:0] HALF_CYC      = 16'h0080;   // first half of a slot ends here
    localparam logic [15:0] SYM4_LAST     = 16'h03ff;   // 4 slots of 256 carrier cycles
    localparam logic [15:0] SYM256_LAST   = 16'hffff;   // 256 slots of 256 carrier cycles
    // Start delimiter shape, carrier cycles from the first pause
    localparam logic [15:0] SOF_LAST      = 16'h03ff;
    localparam logic [15:0] SOF4_GAP      = 16'h0300;
    localparam logic [15:0] SOF256_GAP    = 16'h0200;
    localparam logic [15:0] SOF_TOL_DEF   = 16'h0010;
    // Receiver hold-offs
    localparam int unsigned POWERUP_NS    = 100000;     // 0.1 ms
    localparam int unsigned TURN_NS       = 311500;     // 311.5 us
    localparam int unsigned POWERUP_CYC   = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TURN_CYC_DEF  = TURN_NS / CLK_NS;
    localparam int unsigned HOLD_W        = 13;
    // Reference cycles without a carrier edge before a tick is filled in
    localparam logic [7:0]  FLY_GAP_DEF   = 8'h0c;

    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_SOF  = 4'b0100,
        ST_DATA = 4'b1000
    } rx_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       sof;
        logic       eof;
        logic       err;
        logic       mode4;
        logic       ready;
    } rx_out_s;
endpackage : rf_ppm_pkg

// ### tb/rf_downlink_ppm_decoder_tb.sv
// Self-checking bench for the downlink pulse-position decoder
module rf_downlink_ppm_decoder_tb import rf_ppm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TURN = 40; // Short turnaround keeps the run brief
    logic       ref_clk;
    logic       nrst;
    logic       fieldOn;
    logic       txBusy;
    logic       deep;
    logic       carrierClk;
    logic       pauseN;
    rx_out_s    rxOut;
    logic [7:0] got[$];
    logic [7:0] sent[$];
    int         failCount = 0;
    int         checks    = 0;
    int         sofN      = 0;
    int         eofN      = 0;
    int         errN      = 0;
    int         n;
    int         e0;
    int         s0;

    vcd_reader_model u_rdr (.deep(deep), .carrierClk(carrierClk), .pauseN(pauseN));
    rf_downlink_ppm_decoder #(.TURN_CYC(TURN)) u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .carrierClk(carrierClk), .pauseN(pauseN),
        .fieldOn(fieldOn), .txBusy(txBusy), .rxOut(rxOut));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // strobes last one cycle; looked at every falling edge, where settled
    always @(negedge ref_clk) begin
        if (rxOut.valid === 1'b1) got.push_back(rxOut.data);
        if (rxOut.sof === 1'b1) sofN++;
        if (rxOut.eof === 1'b1) eofN++;
        if (rxOut.err === 1'b1) errN++;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic check_bit(input logic g, input logic e, input string msg);
        checks++;
        if (g !== e) begin
            failCount++;
            $display("wrong value at %0t: %s got %b", $time, msg, g);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string msg);
        checks++;
        if (g !== e) begin
            failCount++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, g, e);
        end
    endtask : check_byte

    task automatic check_count(input int g, input int lo, input int hi, input string msg);
        checks++;
        if (g < lo || g > hi) begin
            failCount++;
            $display("wrong value at %0t: %s count %0d", $time, msg, g);
        end
    endtask : check_count

    // Bounded wait; running out ends the run
    task automatic wait_ready(output int cnt);
        cnt = 0;
        while (rxOut.ready !== 1'b1) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > 3000) begin
                failCount++;
                $display("wrong value at %0t: ready never rose", $time);
                end_sim();
            end
        end
    endtask : wait_ready

    task automatic run_frame(input logic m4, input string name);
        int s;
        int e;
        s = sofN;
        e = eofN;
        got.delete();
        u_rdr.sof(m4);
        foreach (sent[i]) u_rdr.byte4(sent[i]);
        u_rdr.eof();
        repeat (10) @(negedge ref_clk);
        check_count(sofN - s, 1, 1, "start flag");
        check_bit(rxOut.mode4, m4, "coding mode");
        check_count(eofN - e, 1, 1, "end flag");
        check_count(got.size(), sent.size(), sent.size(), "byte count");
        foreach (sent[i]) if (i < got.size()) check_byte(got[i], sent[i], "byte");
        $display("test %s done", name);
    endtask : run_frame

    initial begin
        nrst = 1'b0;
        fieldOn = 1'b0;
        txBusy = 1'b0;
        deep = 1'b0;
        void'($urandom(73143));
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (50) @(negedge ref_clk);
        check_bit(rxOut.ready, 1'b0, "ready without field");
        fieldOn = 1'b1;
        wait_ready(n);
        check_count(n, int'(POWERUP_CYC), int'(POWERUP_CYC) + 8, "power-up delay");
        $display("test power-up done");
        // reader opens every exchange once ready
        // E1h walks all four pair values; one byte per 1-of-4 frame keeps the run short
        sent = {8'he1};
        run_frame(1'b1, "one of four shallow");
        deep = 1'b1;
        sent = {8'($urandom_range(255))};
        run_frame(1'b1, "one of four deep");
        sent.delete();
        run_frame(1'b0, "one of 256 delimiters");
        e0 = errN;
        s0 = sofN;
        u_rdr.mark(0, 640);
        u_rdr.mark(0, 16);
        repeat (10) @(negedge ref_clk);
        check_count(errN - e0, 1, 1, "bad delimiter");
        check_count(sofN - s0, 0, 0, "bad delimiter start");
        e0 = errN;
        u_rdr.sof(1'b1);
        // Second pause lands in slot 1 of the same symbol
        u_rdr.mark(160, 256);
        u_rdr.mark(0, 64);
        repeat (10) @(negedge ref_clk);
        check_count(errN - e0, 1, 1, "two pauses in a symbol");
        $display("test violations done");
        txBusy = 1'b1;
        repeat (2) @(negedge ref_clk);
        check_bit(rxOut.ready, 1'b0, "ready while sending");
        s0 = sofN + errN + eofN;
        u_rdr.mark(0, 64);
        @(negedge ref_clk);
        txBusy = 1'b0;
        wait_ready(n);
        check_count(n, int'(TURN), int'(TURN) + 4, "turnaround");
        repeat (100) @(negedge ref_clk);
        check_count(sofN + errN + eofN - s0, 0, 0, "pause in hold-off");
        $display("test turnaround done");
        end_sim();
    end
endmodule : rf_downlink_ppm_decoder_tb

// ### tb/vcd_reader_model.sv
// Reader-side model: free-running carrier and pulse-position pauses
module vcd_reader_model
    import rf_ppm_pkg::*;
(
    input  wire logic deep,       // High: carrier stops during pauses
    output logic      carrierClk, // Carrier towards the tag
    output logic      pauseN      // Pause, low during a pause
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tk = 1'b0;
    initial pauseN = 1'b1;
    // Field stays up between frames, so the carrier runs free
    initial begin
        forever #200 tk = ~tk;
    end
    // carrier gone only at full depth
    assign carrierClk = tk & ~(deep & ~pauseN);
    task automatic ticks(input int cnt);
        repeat (cnt) @(posedge tk);
    endtask : ticks
    // pause starts at a chosen tick of a segment
    task automatic mark(input int pos, input int len);
        ticks(pos);
        pauseN = 1'b0;
        ticks(8);
        pauseN = 1'b1;
        ticks(len - pos - 8);
    endtask : mark
    // second pause position picks the mode
    task automatic sof(input logic m4);
        mark(0, m4 ? 768 : 512);
        mark(0, m4 ? 256 : 512);
    endtask : sof
    // four pairs, low pair first
    // Pause lands 16 carrier cycles past mid-slot, like a demodulator delay;
    // a pause on the midpoint edge itself is ambiguous at full depth
    task automatic byte4(input logic [7:0] b);
        for (int k = 0; k < 4; k++) begin
            mark(int'(b[2*k +: 2]) * 256 + 144, 1024);
        end
    endtask : byte4
    // pause in first half of the first slot
    task automatic eof();
        mark(32, 64);
    endtask : eof
endmodule : vcd_reader_model
